//--- rtl/control_switch_and_button_logic.sv
// Purpose: Five persistent control switches and twelve front-panel push-buttons.
// Assumes: All inputs synchronous to clock_in; reset_in is the power-on reset.
// Notes:   cpu_reboot_in clears the logical inputs only; switch states survive it.
//
// Notes on behaviour
// - A switch keeps its commanded state until commanded to the opposite state.
// - Only panel graphic and remote link commands move switches; nothing else.
// - Five independent switches, each with its own binary output.
// - Each switch change yields an ON or OFF event, filtered by user selection.
// - Every stored switch event carries the timestamp of the change.
// - Switches survive a processor reboot; logical inputs are cleared by it.
// - Panel switch commands need the selected access level, default configurator.
// - Twelve push-buttons, each with its own status signal.
// - Momentary mode, the default: status active exactly while button is held.
// - Latching mode: each press inverts status, which holds between presses.
// - Each button LED lights red, orange or green from status or another signal.
// - With local/remote consideration on, presses count only in local mode.
// - Presses need the selected access level, default operator.
// - Button status changes only from the front panel, never remotely.
// - Each button has complementary On and Off outputs.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "csb_defines.svh"
`default_nettype none

module control_switch_and_button_logic (
  // Clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       reset_in,
  // AXI4-Lite register slave
  input  wire logic                       axi_awvalid_in,
  input  wire logic [7:0]                 axi_awaddr_in,
  output logic                            axi_awready_out,
  input  wire logic                       axi_wvalid_in,
  input  wire logic [31:0]                axi_wdata_in,
  input  wire logic [3:0]                 axi_wstrb_in,
  output logic                            axi_wready_out,
  output logic                            axi_bvalid_out,
  output logic [1:0]                      axi_bresp_out,
  input  wire logic                       axi_bready_in,
  input  wire logic                       axi_arvalid_in,
  input  wire logic [7:0]                 axi_araddr_in,
  output logic                            axi_arready_out,
  output logic                            axi_rvalid_out,
  output logic [31:0]                     axi_rdata_out,
  output logic [1:0]                      axi_rresp_out,
  input  wire logic                       axi_rready_in,
  // Switch commands
  input  wire csb_pkg::cmd_t              panel_cmd_in,
  input  wire csb_pkg::level_t            session_level_in,
  input  wire csb_pkg::cmd_t              remote_station_link_in,
  input  wire logic                       cpu_reboot_in,
  // Front panel
  input  wire logic [`CSB_NUM_BTN-1:0]    button_in,
  input  wire logic                       local_mode_in,
  input  wire logic [`CSB_NUM_BTN-1:0]    led_signal_in,
  // Switch and logical input outputs
  output logic [`CSB_NUM_SW-1:0]          persistent_control_switch_out,
  output logic [`CSB_NUM_LOGIC-1:0]       logic_input_out,
  // Button outputs
  output logic [`CSB_NUM_BTN-1:0]         btn_on_out,
  output logic [`CSB_NUM_BTN-1:0]         btn_off_out,
  output logic [`CSB_NUM_BTN-1:0]         led_red_out,
  output logic [`CSB_NUM_BTN-1:0]         led_green_out,
  // Events and interrupt
  output logic [`CSB_NUM_SW-1:0]          event_on_out,
  output logic [`CSB_NUM_SW-1:0]          event_off_out,
  output logic [31:0]                     event_time_out,
  output logic                            irq_out
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic level_met(input csb_pkg::level_t have, input logic [1:0] need);
    return logic'(2'(have) >= need);
  endfunction

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic                               aw_full_r;
  logic                               w_full_r;
  logic [7:0]                         waddr_r;
  logic [31:0]                        wdata_r;
  logic [3:0]                         wstrb_r;
  logic [`CSB_CTRL_WIDTH-1:0]         ctrl_r;
  logic [`CSB_NUM_BTN-1:0]            btn_mode_r;
  logic [`CSB_NUM_BTN-1:0]            led_src_r;
  logic [2*`CSB_NUM_BTN-1:0]          led_color_r;
  logic [2*`CSB_NUM_SW-1:0]           int_status_r;
  logic [2*`CSB_NUM_SW-1:0]           int_mask_r;
  logic [31:0]                        time_r;
  logic [`CSB_NUM_BTN-1:0]            btn_q_r;
  logic [`CSB_NUM_BTN-1:0]            latch_r;

  wire aw_hs  = axi_awvalid_in && axi_awready_out;
  wire w_hs   = axi_wvalid_in && axi_wready_out;
  wire b_hs   = axi_bvalid_out && axi_bready_in;
  wire ar_hs  = axi_arvalid_in && axi_arready_out;
  wire r_hs   = axi_rvalid_out && axi_rready_in;
  wire wr_do  = aw_full_r && w_full_r && !axi_bvalid_out;

  wire wr_ctrl  = wr_do && (waddr_r == `CSB_REG_CTRL);
  wire wr_mode  = wr_do && (waddr_r == `CSB_REG_BTN_MODE);
  wire wr_lsrc  = wr_do && (waddr_r == `CSB_REG_LED_SRC);
  wire wr_lcol  = wr_do && (waddr_r == `CSB_REG_LED_COLOR);
  wire wr_ist   = wr_do && (waddr_r == `CSB_REG_INT_STATUS);
  wire wr_imsk  = wr_do && (waddr_r == `CSB_REG_INT_MASK);
  wire wr_logic = wr_do && (waddr_r == `CSB_REG_LOGIC_IN);
  wire wr_ok    = wr_ctrl || wr_mode || wr_lsrc || wr_lcol || wr_ist || wr_imsk || wr_logic
                  || (waddr_r == `CSB_REG_SW_STATE) || (waddr_r == `CSB_REG_BTN_STATUS)
                  || (waddr_r == `CSB_REG_TIMESTAMP);
  wire [31:0] wr_merged_ctrl = merge_strb(32'(ctrl_r), wdata_r, wstrb_r);
  wire [31:0] ist_clear      = merge_strb(32'h0, wdata_r, wstrb_r);

  wire rd_known = (axi_araddr_in <= `CSB_REG_TIMESTAMP) && (axi_araddr_in[1:0] == 2'b00);
  wire [31:0] rd_data =
    (axi_araddr_in == `CSB_REG_CTRL)       ? 32'(ctrl_r) :
    (axi_araddr_in == `CSB_REG_BTN_MODE)   ? 32'(btn_mode_r) :
    (axi_araddr_in == `CSB_REG_LED_SRC)    ? 32'(led_src_r) :
    (axi_araddr_in == `CSB_REG_LED_COLOR)  ? 32'(led_color_r) :
    (axi_araddr_in == `CSB_REG_SW_STATE)   ? 32'(persistent_control_switch_out) :
    (axi_araddr_in == `CSB_REG_BTN_STATUS) ? 32'(btn_on_out) :
    (axi_araddr_in == `CSB_REG_INT_STATUS) ? 32'(int_status_r) :
    (axi_araddr_in == `CSB_REG_INT_MASK)   ? 32'(int_mask_r) :
    (axi_araddr_in == `CSB_REG_LOGIC_IN)   ? 32'(logic_input_out) :
    (axi_araddr_in == `CSB_REG_TIMESTAMP)  ? time_r : 32'h0;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      axi_awready_out <= 1'b1;
      axi_wready_out  <= 1'b1;
      aw_full_r       <= 1'b0;
      w_full_r        <= 1'b0;
      waddr_r         <= 8'h00;
      wdata_r         <= 32'h0;
      wstrb_r         <= 4'h0;
      axi_bvalid_out  <= 1'b0;
      axi_bresp_out   <= `CSB_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        waddr_r         <= axi_awaddr_in;
        aw_full_r       <= 1'b1;
        axi_awready_out <= 1'b0;
      end
      if (w_hs) begin
        wdata_r        <= axi_wdata_in;
        wstrb_r        <= axi_wstrb_in;
        w_full_r       <= 1'b1;
        axi_wready_out <= 1'b0;
      end
      if (wr_do) begin
        aw_full_r      <= 1'b0;
        w_full_r       <= 1'b0;
        axi_bvalid_out <= 1'b1;
        axi_bresp_out  <= wr_ok ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
      end
      if (b_hs) begin
        axi_bvalid_out  <= 1'b0;
        axi_awready_out <= 1'b1;
        axi_wready_out  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      axi_arready_out <= 1'b1;
      axi_rvalid_out  <= 1'b0;
      axi_rdata_out   <= 32'h0;
      axi_rresp_out   <= `CSB_RESP_OKAY;
    end else if (ar_hs) begin
      axi_arready_out <= 1'b0;
      axi_rvalid_out  <= 1'b1;
      axi_rdata_out   <= rd_data;
      axi_rresp_out   <= rd_known ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
    end else if (r_hs) begin
      axi_arready_out <= 1'b1;
      axi_rvalid_out  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  wire [1:0] sw_lvl  = ctrl_r[`CSB_CTRL_SW_LVL];
  wire [1:0] btn_lvl = ctrl_r[`CSB_CTRL_BTN_LVL];
  wire       lr_en   = ctrl_r[`CSB_CTRL_LR_EN];
  wire       ev_on   = ctrl_r[`CSB_CTRL_EV_ON];
  wire       ev_off  = ctrl_r[`CSB_CTRL_EV_OFF];
  wire [31:0] mode_merged  = merge_strb(32'(btn_mode_r), wdata_r, wstrb_r);
  wire [31:0] lsrc_merged  = merge_strb(32'(led_src_r), wdata_r, wstrb_r);
  wire [31:0] lcol_merged  = merge_strb(32'(led_color_r), wdata_r, wstrb_r);
  wire [31:0] imsk_merged  = merge_strb(32'(int_mask_r), wdata_r, wstrb_r);
  wire [31:0] logic_merged = merge_strb(32'(logic_input_out), wdata_r, wstrb_r);

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_r      <= `CSB_CTRL_WIDTH'(`CSB_CTRL_RESET);
      btn_mode_r  <= '0;
      led_src_r   <= '0;
      led_color_r <= '0;
      int_mask_r  <= '0;
    end else begin
      if (wr_ctrl) ctrl_r <= wr_merged_ctrl[`CSB_CTRL_WIDTH-1:0];
      if (wr_mode) btn_mode_r <= mode_merged[11:0];
      if (wr_lsrc) led_src_r <= lsrc_merged[11:0];
      if (wr_lcol) led_color_r <= lcol_merged[23:0];
      if (wr_imsk) int_mask_r <= imsk_merged[9:0];
    end
  end

  // Logical inputs are the volatile alternative to the switches: a reboot wipes them.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      logic_input_out <= '0;
    end else if (cpu_reboot_in) begin
      logic_input_out <= '0;
    end else if (wr_logic) begin
      logic_input_out <= logic_merged[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Persistent control switches
  // ---------------------------------------------------------------------------
  logic [`CSB_NUM_SW-1:0] rem_hit;
  logic [`CSB_NUM_SW-1:0] pan_hit;
  logic [`CSB_NUM_SW-1:0] sw_nxt;
  wire  sw_ok  = level_met(session_level_in, sw_lvl);

  // Remote wins when both ends address the same switch in one cycle.
  for (genvar i = 0; i < `CSB_NUM_SW; i++) begin : g_sw
    assign rem_hit[i] = remote_station_link_in.valid && (remote_station_link_in.idx == 3'(i));
    assign pan_hit[i] = panel_cmd_in.valid && sw_ok && (panel_cmd_in.idx == 3'(i));
    assign sw_nxt[i]  = rem_hit[i] ? remote_station_link_in.on :
                        pan_hit[i] ? panel_cmd_in.on : persistent_control_switch_out[i];
  end

  wire [`CSB_NUM_SW-1:0] sw_rise = sw_nxt & ~persistent_control_switch_out;
  wire [`CSB_NUM_SW-1:0] sw_fall = ~sw_nxt & persistent_control_switch_out;
  wire [`CSB_NUM_SW-1:0] ev_on_nxt  = sw_rise & {`CSB_NUM_SW{ev_on}};
  wire [`CSB_NUM_SW-1:0] ev_off_nxt = sw_fall & {`CSB_NUM_SW{ev_off}};

  // Only reset_in clears the switches; cpu_reboot_in has no path here.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      persistent_control_switch_out <= '0;
      event_on_out                  <= '0;
      event_off_out                 <= '0;
      event_time_out                <= 32'h0;
      time_r                        <= 32'h0;
    end else begin
      persistent_control_switch_out <= sw_nxt;
      event_on_out                  <= ev_on_nxt;
      event_off_out                 <= ev_off_nxt;
      time_r                        <= time_r + 32'h1;
      if (|(ev_on_nxt | ev_off_nxt)) event_time_out <= time_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt: sticky status, write one to clear, set wins over clear
  // ---------------------------------------------------------------------------
  wire [2*`CSB_NUM_SW-1:0] int_set = {ev_off_nxt, ev_on_nxt};
  wire [2*`CSB_NUM_SW-1:0] int_clr = wr_ist ? ist_clear[9:0] : '0;
  wire [2*`CSB_NUM_SW-1:0] int_nxt = (int_status_r & ~int_clr) | int_set;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      int_status_r <= '0;
      irq_out      <= 1'b0;
    end else begin
      int_status_r <= int_nxt;
      irq_out      <= |(int_nxt & (wr_imsk ? imsk_merged[9:0] : int_mask_r));
    end
  end

  // ---------------------------------------------------------------------------
  // Push-buttons and LEDs
  // ---------------------------------------------------------------------------
  // Only front-panel inputs reach this logic; remote commands have no path in.
  wire btn_gate = level_met(session_level_in, btn_lvl) && (!lr_en || local_mode_in);
  wire [`CSB_NUM_BTN-1:0] press     = button_in & ~btn_q_r & {`CSB_NUM_BTN{btn_gate}};
  wire [`CSB_NUM_BTN-1:0] latch_nxt = btn_mode_r & (latch_r ^ press);
  wire [`CSB_NUM_BTN-1:0] stat_nxt  = (btn_mode_r & latch_nxt)
                                      | (~btn_mode_r & button_in & {`CSB_NUM_BTN{btn_gate}});
  logic [`CSB_NUM_BTN-1:0] red_nxt;
  logic [`CSB_NUM_BTN-1:0] green_nxt;

  for (genvar i = 0; i < `CSB_NUM_BTN; i++) begin : g_led
    wire        act = led_src_r[i] ? led_signal_in[i] : stat_nxt[i];
    wire [1:0]  col = led_color_r[2*i +: 2];
    assign red_nxt[i]   = act && ((col == 2'(csb_pkg::LED_RED)) || (col == 2'(csb_pkg::LED_ORANGE)));
    assign green_nxt[i] = act && ((col == 2'(csb_pkg::LED_GREEN)) || (col == 2'(csb_pkg::LED_ORANGE)));
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      btn_q_r       <= '0;
      latch_r       <= '0;
      btn_on_out    <= '0;
      btn_off_out   <= '1;
      led_red_out   <= '0;
      led_green_out <= '0;
    end else begin
      btn_q_r       <= button_in;
      latch_r       <= latch_nxt;
      btn_on_out    <= stat_nxt;
      btn_off_out   <= ~stat_nxt;
      led_red_out   <= red_nxt;
      led_green_out <= green_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_press1;
    btn_mode_r[1] && press[1] && !wr_do;
  endsequence

  property p_sw_hold;
    (rem_hit == '0) && (pan_hit == '0) |=> $stable(persistent_control_switch_out);
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("switch moved without command");

  property p_remote_sets;
    remote_station_link_in.valid && remote_station_link_in.idx == 3'd2
      |=> persistent_control_switch_out[2] == $past(remote_station_link_in.on);
  endproperty
  a_remote_sets: assert property (p_remote_sets) else $error("remote command not applied");

  property p_panel_level;
    panel_cmd_in.valid && !level_met(session_level_in, sw_lvl) && !remote_station_link_in.valid
      |=> $stable(persistent_control_switch_out);
  endproperty
  a_panel_level: assert property (p_panel_level) else $error("panel command bypassed level");

  property p_event_on;
    sw_rise[1] && ev_on |=> event_on_out[1] && !event_off_out[1];
  endproperty
  a_event_on: assert property (p_event_on) else $error("missing switch on event");

  property p_event_time;
    (event_on_out != '0) || (event_off_out != '0) |-> event_time_out == time_r - 32'h1;
  endproperty
  a_event_time: assert property (p_event_time) else $error("event timestamp wrong");

  property p_reboot;
    cpu_reboot_in && !remote_station_link_in.valid && !panel_cmd_in.valid
      |=> logic_input_out == '0 && $stable(persistent_control_switch_out);
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot handling wrong");

  property p_momentary;
    !btn_mode_r[0] && btn_gate && button_in[0] |=> btn_on_out[0];
  endproperty
  a_momentary: assert property (p_momentary) else $error("momentary status not active");

  property p_toggle;
    s_press1 |=> btn_on_out[1] != $past(btn_on_out[1]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("latching press did not toggle");

  property p_local;
    lr_en && !local_mode_in && !btn_mode_r[0] |=> !btn_on_out[0];
  endproperty
  a_local: assert property (p_local) else $error("button active in remote mode");

  property p_gate_hold;
    btn_mode_r[1] && $past(btn_mode_r[1]) && !$past(btn_gate) && !$past(wr_do)
      |-> btn_on_out[1] == $past(btn_on_out[1]);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("rejected press toggled");

  property p_complement;
    btn_on_out == ~btn_off_out;
  endproperty
  a_complement: assert property (p_complement) else $error("on and off outputs agree");

endmodule

`default_nettype wire

//--- rtl/csb_defines.svh
// Purpose: Register map, field positions and reset values of the switch and button block.
// Assumes: AXI4-Lite register window with 8-bit byte addresses.
// Notes:   Definitions only.
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define CSB_REG_CTRL       8'h00
`define CSB_REG_BTN_MODE   8'h04
`define CSB_REG_LED_SRC    8'h08
`define CSB_REG_LED_COLOR  8'h0c
`define CSB_REG_SW_STATE   8'h10
`define CSB_REG_BTN_STATUS 8'h14
`define CSB_REG_INT_STATUS 8'h18
`define CSB_REG_INT_MASK   8'h1c
`define CSB_REG_LOGIC_IN   8'h20
`define CSB_REG_TIMESTAMP  8'h24

// ---------------------------------------------------------------------------
// Fields, sizes and reset values
// ---------------------------------------------------------------------------
`define CSB_NUM_SW         5
`define CSB_NUM_BTN        12
`define CSB_NUM_LOGIC      8
`define CSB_CTRL_RESET     32'h0000_0066
`define CSB_CTRL_SW_LVL    1:0
`define CSB_CTRL_BTN_LVL   3:2
`define CSB_CTRL_LR_EN     4
`define CSB_CTRL_EV_ON     5
`define CSB_CTRL_EV_OFF    6
`define CSB_CTRL_WIDTH     7
`define CSB_INT_OFF_LSB    5
`define CSB_RESP_OKAY      2'b00
`define CSB_RESP_SLVERR    2'b10

`endif

//--- rtl/csb_pkg.sv
// Purpose: Types shared by the switch and button block and its bench.
// Assumes: Nothing beyond the defines header.
// Notes:   Access levels are ordered so that a higher code includes the lower ones.
`default_nettype none

package csb_pkg;

  typedef enum logic [1:0] {
    LVL_USER,
    LVL_OPERATOR,
    LVL_CONFIGURATOR,
    LVL_SUPER
  } level_t;

  typedef enum logic [1:0] {
    LED_OFF,
    LED_RED,
    LED_ORANGE,
    LED_GREEN
  } led_color_t;

  // One switch command: index 0..4 selects the switch, on gives the target state.
  typedef struct packed {
    logic       valid;
    logic [2:0] idx;
    logic       on;
  } cmd_t;

endpackage

`default_nettype wire

//--- sim/control_switch_and_button_logic_test.sv
// Purpose: Self-checking bench of the switch and button block.
// Assumes: Register map and reset values as in csb_defines.svh.
// Notes:   Switch events are predicted into a queue and matched by a monitor.
`include "csb_defines.svh"
`default_nettype none

module control_switch_and_button_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0, reset_in = 1, cpu_reboot_in = 0, local_mode_in = 0;
  logic axi_awvalid_in = 0, axi_wvalid_in = 0, axi_bready_in = 0;
  logic axi_arvalid_in = 0, axi_rready_in = 0;
  logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out;
  logic axi_rvalid_out, irq_out;
  logic [7:0] axi_awaddr_in = 8'h00, axi_araddr_in = 8'h00, logic_input_out;
  logic [3:0] axi_wstrb_in = 4'hf;
  logic [1:0] axi_bresp_out, axi_rresp_out, evsel = 2'h3;
  logic [31:0] axi_wdata_in = 32'h0, axi_rdata_out, event_time_out;
  logic [31:0] last_t = 32'h0, rnd = 32'h8;
  logic [11:0] button_in = 12'h0, led_signal_in = 12'h0;
  logic [11:0] btn_on_out, btn_off_out, led_red_out, led_green_out;
  logic [4:0] persistent_control_switch_out, event_on_out, event_off_out, sw_exp = 5'h0;
  csb_pkg::level_t session_level_in = csb_pkg::LVL_SUPER;
  csb_pkg::cmd_t panel_cmd_in, remote_station_link_in;
  logic [9:0] evq[$];
  int errors = 0, n_checks = 0;

  control_switch_and_button_logic control_switch_and_button_logic_inst (.clock_in, .reset_in,
    .axi_awvalid_in, .axi_awaddr_in, .axi_awready_out, .axi_wvalid_in, .axi_wdata_in,
    .axi_wstrb_in, .axi_wready_out, .axi_bvalid_out, .axi_bresp_out, .axi_bready_in,
    .axi_arvalid_in, .axi_araddr_in, .axi_arready_out, .axi_rvalid_out, .axi_rdata_out,
    .axi_rresp_out, .axi_rready_in, .panel_cmd_in, .session_level_in, .remote_station_link_in,
    .cpu_reboot_in, .button_in, .local_mode_in, .led_signal_in, .persistent_control_switch_out,
    .logic_input_out, .btn_on_out, .btn_off_out, .led_red_out, .led_green_out, .event_on_out,
    .event_off_out, .event_time_out, .irq_out);
  panel_station_model panel_station_model_inst (.clock_in, .panel_cmd_out(panel_cmd_in),
    .remote_cmd_out(remote_station_link_in));

  initial forever #12.5 clock_in = ~clock_in;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic lim(input int n);
    if (n >= 99) begin
      chk(0, "bus timeout");
      summarize;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    axi_awaddr_in <= a;
    axi_wdata_in <= d;
    axi_awvalid_in <= 1;
    axi_wvalid_in <= 1;
    axi_bready_in <= 1;
    n = 0;
    do begin
      @(posedge clock_in);
      if (axi_awready_out) axi_awvalid_in <= 0;
      if (axi_wready_out) axi_wvalid_in <= 0;
      n++;
    end while (!axi_bvalid_out && n < 99);
    lim(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    axi_araddr_in <= a;
    axi_arvalid_in <= 1;
    axi_rready_in <= 1;
    n = 0;
    do begin
      @(posedge clock_in);
      if (axi_arready_out) axi_arvalid_in <= 0;
      n++;
    end while (!axi_rvalid_out && n < 99);
    lim(n);
    chk(axi_rdata_out === e && axi_rresp_out === r, "read");
  endtask
  // Accepted commands that change state predict an event when that kind is stored.
  task automatic sw(input logic [1:0] who, input logic [2:0] i, input logic o, input logic acc);
    if (acc && i < 5 && sw_exp[i] !== o) begin
      if (o ? evsel[0] : evsel[1]) evq.push_back(o ? {5'h1 << i, 5'h0} : {5'h0, 5'h1 << i});
      sw_exp[i] = o;
    end
    panel_station_model_inst.send(who, i, o);
    tick(2);
    chk(persistent_control_switch_out === sw_exp, "switch state");
  endtask
  task automatic press(input logic [11:0] b);
    button_in <= b;
    tick(2);
    button_in <= 12'h0;
    tick(2);
  endtask

  always @(posedge clock_in) begin
    if (!reset_in && (event_on_out | event_off_out) !== 5'h0) begin
      chk(evq.size() > 0 && {event_on_out, event_off_out} === evq[0], "event");
      chk(event_time_out > last_t, "event time");
      last_t = event_time_out;
      if (evq.size() > 0) void'(evq.pop_front());
    end
  end

  initial begin
    tick(20);
    reset_in <= 0;
    tick(1);
    chk(btn_off_out === 12'hfff && persistent_control_switch_out === 5'h0, "reset");
    rd(`CSB_REG_CTRL, 32'h66, `CSB_RESP_OKAY);
    rd(8'h28, 32'h0, `CSB_RESP_SLVERR);
    $display("registers done");
    for (int k = 0; k < 16; k++) begin
      rnd = xs(rnd);
      sw(rnd[4] ? 2'h2 : 2'h1, rnd[2:0], rnd[3], 1'b1);
    end
    session_level_in <= csb_pkg::LVL_OPERATOR;
    sw(2'h1, 3'h0, ~sw_exp[0], 1'b0);
    sw(2'h2, 3'h0, ~sw_exp[0], 1'b1);
    session_level_in <= csb_pkg::LVL_CONFIGURATOR;
    sw(2'h1, 3'h0, ~sw_exp[0], 1'b1);
    $display("switches done");
    wr(`CSB_REG_CTRL, 32'h26);
    evsel = 2'h1;
    wr(`CSB_REG_INT_MASK, 32'h3ff);
    wr(`CSB_REG_INT_STATUS, 32'h3ff);
    sw(2'h2, 3'h4, 1'b0, 1'b1);
    sw(2'h2, 3'h4, 1'b1, 1'b1);
    sw(2'h2, 3'h4, 1'b0, 1'b1);
    rd(`CSB_REG_INT_STATUS, 32'h10, `CSB_RESP_OKAY);
    chk(irq_out === 1'b1, "irq set");
    wr(`CSB_REG_INT_STATUS, 32'h10);
    tick(2);
    chk(irq_out === 1'b0, "irq clear");
    wr(`CSB_REG_LOGIC_IN, 32'ha5);
    rd(`CSB_REG_LOGIC_IN, 32'ha5, `CSB_RESP_OKAY);
    cpu_reboot_in <= 1;
    tick(1);
    cpu_reboot_in <= 0;
    tick(2);
    rd(`CSB_REG_LOGIC_IN, 32'h0, `CSB_RESP_OKAY);
    chk(persistent_control_switch_out === sw_exp && logic_input_out === 8'h0, "reboot");
    $display("events done");
    wr(`CSB_REG_LED_COLOR, 32'h3);
    button_in <= 12'h001;
    tick(2);
    chk(btn_on_out === 12'h1 && btn_off_out === 12'hffe && led_green_out === 12'h1, "held");
    button_in <= 12'h0;
    tick(2);
    chk(btn_on_out === 12'h0, "released");
    wr(`CSB_REG_BTN_MODE, 32'h2);
    press(12'h002);
    chk(btn_on_out === 12'h2 && btn_off_out === 12'hffd, "latch on");
    session_level_in <= csb_pkg::LVL_USER;
    press(12'h002);
    chk(btn_on_out === 12'h2, "level gate");
    session_level_in <= csb_pkg::LVL_SUPER;
    wr(`CSB_REG_CTRL, 32'h36);
    press(12'h003);
    chk(btn_on_out === 12'h2, "remote gate");
    local_mode_in <= 1;
    sw(2'h2, 3'h2, ~sw_exp[2], 1'b1);
    chk(btn_on_out === 12'h2, "remote cmd");
    press(12'h002);
    chk(btn_on_out === 12'h0, "latch off");
    wr(`CSB_REG_LED_SRC, 32'h2);
    wr(`CSB_REG_LED_COLOR, 32'h7);
    rnd = xs(rnd);
    led_signal_in <= rnd[11:0];
    tick(2);
    chk(led_red_out[1] === rnd[1] && led_green_out[1] === 1'b0, "led");
    $display("buttons done");
    chk(evq.size() == 0, "missing event");
    summarize;
  end
endmodule

`default_nettype wire

//--- sim/panel_station_model.sv
// Purpose: Operator panel graphic and remote station link command source.
// Assumes: Commands are one-cycle pulses launched after a rising edge.
// Notes:   Idle payload keeps changing so a stale command cannot pass as valid.
`default_nettype none

module panel_station_model (
  // Clock
  input  wire logic           clock_in,
  // Commands
  output var csb_pkg::cmd_t   panel_cmd_out,
  output var csb_pkg::cmd_t   remote_cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] req   = 2'h0;
  logic [2:0] idx_q = 3'h0;
  logic       on_q  = 1'b0;
  logic [3:0] noise = 4'h0;
  always @(posedge clock_in) begin
    noise <= noise + 4'h5;
    panel_cmd_out <= req[0] ? {1'b1, idx_q, on_q} : {1'b0, noise};
    remote_cmd_out <= req[1] ? {1'b1, idx_q, on_q} : {1'b0, ~noise};
  end
  // Bit 0 of who selects the panel, bit 1 the remote link.
  task automatic send(input logic [1:0] who, input logic [2:0] i, input logic o);
    req <= who;
    idx_q <= i;
    on_q <= o;
    @(posedge clock_in);
    req <= 2'h0;
  endtask
endmodule

`default_nettype wire
